// *** src/tvio_port.v ***
`timescale 1ns/1ns
`default_nettype none
`include "tvio_consts.vh"

module tvio_port (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ext_reset_n,
  input  wire [39:0] pad_in,
  output wire [39:0] pad_out,
  output wire [39:0] pad_oe,
  output wire [39:0] pad_cmos_sel,
  output wire [39:0] alt_pin_level,
  input  wire [3:0]  twowire_clock_drive,
  input  wire [3:0]  twowire_data_drive,
  output wire [3:0]  twowire_clock_in,
  output wire [3:0]  twowire_data_in,
  input  wire [7:0]  pulse_out,
  output wire [7:0]  analog_path_en,
  input  wire        delayed_reset_src,
  input  wire        pixel_tick
);

  // ****************************************
  // state
  // ****************************************
  reg  [7:0]  data_q [0:4];
  reg  [7:0]  cfg0_q [0:4];
  reg  [7:0]  cfg1_q [0:4];
  reg  [7:0]  cfg2_q [0:4];
  reg         alt_sel_q;
  reg         p5b0_hold_q;
  reg         pix_half_q;

  reg         aw_have_q;
  reg  [7:0]  aw_idx_q;
  reg         w_have_q;
  reg  [7:0]  w_data_q;
  reg         w_lane_q;

  wire [39:0] latch_flat;
  wire [39:0] c0_flat;
  wire [39:0] c1_flat;
  wire [39:0] c2_flat;
  wire [39:0] din;
  wire [39:0] alt_active;
  reg  [39:0] alt_drive;

  wire        wr_fire;
  wire        rd_fire;
  wire [5:0]  wr_dec;
  wire [5:0]  rd_dec;
  wire [7:0]  rd_idx;
  reg  [7:0]  rd_byte;
  reg         rd_hit;
  wire        regs_rst;
  integer     k;

  // ****************************************
  // address decode
  // ****************************************
  // {hit, kind[1:0], slot[2:0]}; kind 0 data, 1..3 config 0..2
  function [5:0] tvio_decode;
    input [7:0] idx;
    integer s;
    integer r;
    begin
      tvio_decode = 6'h00;
      if (idx == `TVIO_IDX_P0_DATA) begin
        tvio_decode = {1'b1, 2'h0, 3'h0};
      end else if (idx == `TVIO_IDX_P2_DATA) begin
        tvio_decode = {1'b1, 2'h0, 3'h1};
      end else if (idx == `TVIO_IDX_P3_DATA) begin
        tvio_decode = {1'b1, 2'h0, 3'h2};
      end else if (idx == `TVIO_IDX_P4_DATA) begin
        tvio_decode = {1'b1, 2'h0, 3'h3};
      end else if (idx == `TVIO_IDX_P5_DATA) begin
        tvio_decode = {1'b1, 2'h0, 3'h4};
      end else begin
        for (s = 0; s < `TVIO_NSLOTS; s = s + 1) begin
          for (r = 0; r < 3; r = r + 1) begin
            if (idx == `TVIO_IDX_CFG_BASE + s[7:0] * 8'h03 + r[7:0]) begin
              tvio_decode = {1'b1, r[1:0] + 2'h1, s[2:0]};
            end
          end
        end
      end
    end
  endfunction

  // ****************************************
  // bus handshakes
  // ****************************************
  // address and data taken in either order; response after both
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign wr_fire       = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_dec        = tvio_decode(aw_idx_q);

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_idx        = s_axi_araddr[9:2];
  assign rd_dec        = tvio_decode(rd_idx);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q    <= 1'b0;
      aw_idx_q     <= 8'h00;
      w_have_q     <= 1'b0;
      w_data_q     <= 8'h00;
      w_lane_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TVIO_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_dec[5] || aw_idx_q == `TVIO_IDX_ALT_SEL) ?
                        `TVIO_RESP_OKAY : `TVIO_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // register reset
  // ****************************************
  // pin reset clears the settings as well, so pins come back
  // bidirectional and port 5 bit 0 held when it lifts;
  // it needs one clock edge while low, the pins need none
  assign regs_rst = !aresetn || !ext_reset_n;

  // ****************************************
  // register file
  // ****************************************
  // upper byte lanes hold nothing; lane 0 off means no change
  always @(posedge aclk) begin
    if (regs_rst) begin
      for (k = 0; k < `TVIO_NSLOTS; k = k + 1) begin
        data_q[k] <= `TVIO_DATA_RST;
        cfg0_q[k] <= `TVIO_CFG_RST;
        cfg1_q[k] <= `TVIO_CFG_RST;
        cfg2_q[k] <= `TVIO_CFG_RST;
      end
      alt_sel_q   <= `TVIO_ALT_SEL_RST;
      p5b0_hold_q <= 1'b1;
    end else if (wr_fire && w_lane_q) begin
      if (wr_dec[5]) begin
        case (wr_dec[4:3])
          2'h0: data_q[wr_dec[2:0]] <= w_data_q;
          2'h1: cfg0_q[wr_dec[2:0]] <= w_data_q;
          2'h2: cfg1_q[wr_dec[2:0]] <= w_data_q;
          default: cfg2_q[wr_dec[2:0]] <= w_data_q;
        endcase
        // any port 5 configuration write releases the reset mode
        if (wr_dec[4:3] != 2'h0 && wr_dec[2:0] == 3'h4) begin
          p5b0_hold_q <= 1'b0;
        end
      end else if (aw_idx_q == `TVIO_IDX_ALT_SEL) begin
        alt_sel_q <= w_data_q[0];
      end
    end
  end

  // ****************************************
  // flat views for the pin cells
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `TVIO_NSLOTS; g = g + 1) begin : flat
      assign latch_flat[g*8 +: 8] = data_q[g];
      assign c0_flat[g*8 +: 8]    = cfg0_q[g];
      assign c1_flat[g*8 +: 8]    = cfg1_q[g];
      assign c2_flat[g*8 +: 8]    = cfg2_q[g];
    end
  endgenerate

  // ****************************************
  // pixel clock halving
  // ****************************************
  // one toggle per pixel tick from the clock unit
  always @(posedge aclk) begin
    if (!aresetn) begin
      pix_half_q <= 1'b0;
    end else if (pixel_tick) begin
      pix_half_q <= ~pix_half_q;
    end
  end

  // ****************************************
  // alternate-function routing
  // ****************************************
  // port 4 bits 0/1 shared: two-wire channel 3 or pulse outputs 0/1
  always @* begin
    alt_drive     = 40'h0000000000;
    alt_drive[12] = twowire_clock_drive[0];
    alt_drive[13] = twowire_data_drive[0];
    alt_drive[20] = twowire_clock_drive[1];
    alt_drive[21] = twowire_data_drive[1];
    alt_drive[16] = twowire_clock_drive[2];
    alt_drive[17] = twowire_data_drive[2];
    alt_drive[24] = alt_sel_q ? pulse_out[0] : twowire_clock_drive[3];
    alt_drive[25] = alt_sel_q ? pulse_out[1] : twowire_data_drive[3];
    alt_drive[37] = pulse_out[2];
    alt_drive[38] = pulse_out[3];
    alt_drive[31:28] = pulse_out[7:4];
    alt_drive[`TVIO_PIN_P5B0] = delayed_reset_src;
    alt_drive[`TVIO_PIN_P2B7] = pix_half_q;
  end

  // ****************************************
  // pin cells
  // ****************************************
  generate
    for (g = 0; g < `TVIO_NPINS; g = g + 1) begin : pin
      localparam IS_P5B0 = (g == `TVIO_PIN_P5B0) ? 1 : 0;
      wire [2:0] cfg_eff;

      // port 5 bit 0 held in push-pull alternate mode until released
      assign cfg_eff = (IS_P5B0 != 0 && p5b0_hold_q) ? `TVIO_P5B0_RST_MODE :
                       {c2_flat[g], c1_flat[g], c0_flat[g]};

      tvio_pin_cell #(
        .SCHMITT (`TVIO_SCHMITT_MASK >> g & 40'h1),
        .ANALOG  (`TVIO_ANALOG_MASK >> g & 40'h1),
        .RST_ALT (IS_P5B0)
      ) u_cell (
        .cfg_c0      (cfg_eff[0]),
        .cfg_c1      (cfg_eff[1]),
        .cfg_c2      (cfg_eff[2]),
        .latch       (latch_flat[g]),
        .alt_drive   (alt_drive[g]),
        .ext_reset_n (ext_reset_n),
        .pad_in      (pad_in[g]),
        .pad_out     (pad_out[g]),
        .pad_oe      (pad_oe[g]),
        .din         (din[g]),
        .cmos_sel    (pad_cmos_sel[g]),
        .alt_active  (alt_active[g])
      );
    end
  endgenerate

  // ****************************************
  // alternate inputs
  // ****************************************
  // wired to the pin in every mode but open-drain alternate on analog pins
  assign alt_pin_level = din;

  assign twowire_clock_in = {din[24], din[16], din[20], din[12]};
  assign twowire_data_in  = {din[25], din[17], din[21], din[13]};

  // channel order 7..0: p0.7..p0.4, p2.3..p2.1, p0.3
  assign analog_path_en = {alt_active[7:4], alt_active[11:9], alt_active[3]};

  // ****************************************
  // read path
  // ****************************************
  // output and alternate bits read the latch, others the pin
  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (rd_dec[5]) begin
      case (rd_dec[4:3])
        2'h0: rd_byte = (data_q[rd_dec[2:0]] & cfg1_q[rd_dec[2:0]]) |
                        (din[rd_dec[2:0]*8 +: 8] & ~cfg1_q[rd_dec[2:0]]);
        2'h1: rd_byte = cfg0_q[rd_dec[2:0]];
        2'h2: rd_byte = cfg1_q[rd_dec[2:0]];
        default: rd_byte = cfg2_q[rd_dec[2:0]];
      endcase
    end else if (rd_idx == `TVIO_IDX_ALT_SEL) begin
      rd_byte = {6'h00, p5b0_hold_q, alt_sel_q};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `TVIO_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_hit ? `TVIO_RESP_OKAY : `TVIO_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** src/tvio_consts.vh ***
`ifndef TVIO_CONSTS_VH
`define TVIO_CONSTS_VH

// ****************************************
// register indices, byte address = 4 * index
// ****************************************
`define TVIO_IDX_P0_DATA   8'hE0
`define TVIO_IDX_P2_DATA   8'hE2
`define TVIO_IDX_P3_DATA   8'hE3
`define TVIO_IDX_P4_DATA   8'hE4
`define TVIO_IDX_P5_DATA   8'hE5
`define TVIO_IDX_CFG_BASE  8'hF0
`define TVIO_IDX_ALT_SEL   8'hFF

// ****************************************
// reset values
// ****************************************
`define TVIO_DATA_RST      8'hFF
`define TVIO_CFG_RST       8'h00
`define TVIO_ALT_SEL_RST   1'b0

// ****************************************
// mode field {cfg1, cfg0} per bit, cfg2 picks open-drain; port 5 bit 0 reset mode as {cfg2, cfg1, cfg0}
// ****************************************
`define TVIO_MODE_BIDIR    2'h0
`define TVIO_MODE_INPUT    2'h1
`define TVIO_MODE_OUTPUT   2'h2
`define TVIO_MODE_ALT      2'h3
`define TVIO_P5B0_RST_MODE 3'h3

// ****************************************
// pin feature masks, flat index = slot * 8 + bit
// slots: 0 port0, 1 port2, 2 port3, 3 port4, 4 port5
// ****************************************
`define TVIO_SCHMITT_MASK  40'h00037B3100
`define TVIO_ANALOG_MASK   40'h0000000EF8
`define TVIO_NPINS         40
`define TVIO_NSLOTS        5

// ****************************************
// alternate-function pin positions
// ****************************************
`define TVIO_PIN_P5B0      32
`define TVIO_PIN_P2B7      15

// ****************************************
// bus answers
// ****************************************
`define TVIO_RESP_OKAY     2'h0
`define TVIO_RESP_SLVERR   2'h2

`endif

// *** src/tvio_pin_cell.v ***
`timescale 1ns/1ns
`default_nettype none
`include "tvio_consts.vh"

module tvio_pin_cell #(
  parameter SCHMITT = 0,
  parameter ANALOG  = 0,
  parameter RST_ALT = 0
) (
  input  wire       cfg_c0,
  input  wire       cfg_c1,
  input  wire       cfg_c2,
  input  wire       latch,
  input  wire       alt_drive,
  input  wire       ext_reset_n,
  input  wire       pad_in,
  output reg        pad_out,
  output reg        pad_oe,
  output wire       din,
  output wire       cmos_sel,
  output wire       alt_active
);

  wire [1:0] mode;
  wire       level;

  assign mode = {cfg_c1, cfg_c0};

  // ****************************************
  // driver
  // ****************************************
  always @* begin
    pad_out = 1'b0;
    pad_oe  = 1'b0;
    if (!ext_reset_n) begin
      // pin forced without waiting for a clock edge
      if (RST_ALT != 0) begin
        pad_out = alt_drive;
        pad_oe  = 1'b1;
      end
    end else begin
      case (mode)
        `TVIO_MODE_BIDIR: begin
          // no pull-up exists: a one leaves the pin floating
          pad_oe = ~latch;
        end
        `TVIO_MODE_INPUT: begin
          pad_oe = 1'b0;
        end
        `TVIO_MODE_OUTPUT: begin
          pad_out = cfg_c2 ? 1'b0 : latch;
          pad_oe  = cfg_c2 ? ~latch : 1'b1;
        end
        default: begin
          pad_out = cfg_c2 ? 1'b0 : alt_drive;
          pad_oe  = cfg_c2 ? ~alt_drive : 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // input path
  // ****************************************
  // own drive seen back, so a peripheral reads what it sends
  assign level = pad_oe ? pad_out : pad_in;

  // analog pin in open-drain alternate mode: no digital load
  assign din = (ANALOG != 0 && mode == `TVIO_MODE_ALT && cfg_c2) ? 1'b0 : level;

  // fixed schmitt pins ignore the level choice
  assign cmos_sel = (SCHMITT == 0) && cfg_c2 && !cfg_c1;

  assign alt_active = ext_reset_n && (mode == `TVIO_MODE_ALT);

endmodule

`default_nettype wire

// *** sim/tvio_board.sv ***
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// board pins: external drivers, no pull-ups
// ****************************************
module tvio_board (
  input  wire logic        aclk,
  input  wire logic [39:0] pad_out,
  input  wire logic [39:0] pad_oe,
  input  wire logic [39:0] ext_en,
  input  wire logic [39:0] ext_val,
  output wire logic [39:0] pad_in
);
  logic [39:0] float_q = 40'h55_5555_5555;

  // undriven pins wander every cycle, so a stale level never passes
  always @(posedge aclk) begin
    float_q <= ~float_q;
  end

  // device drive wins; the board only drives released pins
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & float_q);
endmodule

`default_nettype wire

// *** sim/tvio_port_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "tvio_consts.vh"

// ****************************************
// port checker
// ****************************************
module tvio_port_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ext_reset_n,
  input wire logic        delayed_reset_src,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [39:0] pad_in,
  input wire logic [39:0] pad_out,
  input wire logic [39:0] pad_oe,
  input wire logic [39:0] pad_cmos_sel,
  input wire logic [39:0] alt_pin_level,
  input wire logic [3:0]  twowire_clock_in,
  input wire logic [3:0]  twowire_data_in
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  p50_pinrst_a:
    assert property (!ext_reset_n |-> pad_oe[32] && pad_out[32] == delayed_reset_src)
    else $error("port5 bit0 not driven in pin reset");
  pins_float_a:
    assert property (!ext_reset_n |-> pad_oe[31:0] == 32'h0 && pad_oe[39:33] == 7'h0)
    else $error("pin driven during pin reset");
  wr_answer_a:
    // both halves held one cycle, the answer registered the next
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  wr_block_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  schmitt_fixed_a:
    assert property ((pad_cmos_sel & `TVIO_SCHMITT_MASK) == 40'h0)
    else $error("schmitt pin level selectable");
  twowire_map_a:
    assert property (twowire_clock_in == {alt_pin_level[24], alt_pin_level[16],
                     alt_pin_level[20], alt_pin_level[12]} && twowire_data_in ==
                     {alt_pin_level[25], alt_pin_level[17], alt_pin_level[21],
                      alt_pin_level[13]})
    else $error("two-wire input mapped wrong");
  af_feedback_a:
    assert property ((pad_oe & (alt_pin_level ^ pad_out)) == 40'h0)
    else $error("driven pin not fed back");
  af_input_a:
    assert property ((~pad_oe & ~`TVIO_ANALOG_MASK & (alt_pin_level ^ pad_in)) == 40'h0)
    else $error("alternate input not at pin level");

  cover property (!ext_reset_n);
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind tvio_port tvio_port_chk i_tvio_port_chk (.aclk, .aresetn, .ext_reset_n,
  .delayed_reset_src, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .pad_in, .pad_out, .pad_oe, .pad_cmos_sel,
  .alt_pin_level, .twowire_clock_in, .twowire_data_in);

`default_nettype wire

// *** sim/tvio_port_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "tvio_consts.vh"

// ****************************************
// port testbench
// ****************************************
module tvio_port_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, ext_reset_n = 1'b1;
  logic        delayed_reset_src = 1'b0, pixel_tick = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0, twowire_clock_drive = 4'hF, twowire_data_drive = 4'hF;
  logic [7:0]  pulse_out = 8'h00, rd_q;
  logic [39:0] ext_en = 40'hFF_FFFF_FFFF, ext_val = 40'hFF_FFFF_FFFF;
  logic [1:0]  rsp_q;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [39:0]  pad_in, pad_out, pad_oe, pad_cmos_sel, alt_pin_level;
  wire [3:0]   twowire_clock_in, twowire_data_in;
  wire [7:0]   analog_path_en;
  int          miscompares = 0, tests_run = 0;

  always #4 aclk = ~aclk;

  tvio_port i_tvio_port (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_reset_n, .pad_in, .pad_out, .pad_oe,
    .pad_cmos_sel, .alt_pin_level, .twowire_clock_drive, .twowire_data_drive,
    .twowire_clock_in, .twowire_data_in, .pulse_out, .analog_path_en, .delayed_reset_src,
    .pixel_tick);
  tvio_board i_tvio_board (.aclk, .pad_out, .pad_oe, .ext_en, .ext_val, .pad_in);

  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wait_fail;
    miscompares++;
    $display("mismatch handshake expected answer seen none");
    end_of_test;
  endtask

  // bus master: request held until its ready, answer taken at its edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st = 4'h1);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 40) wait_fail();
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp_q = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] idx);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    // rready follows rvalid, so the answer must stand a cycle unasked
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      if (n > 40) wait_fail();
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    rd_q = s_axi_rdata[7:0];
    rsp_q = s_axi_rresp;
  endtask

  initial begin
    logic err;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // indices E0..FF: data, config, select and the holes between
    for (int i = 224; i < 256; i++) begin
      err = (i == 225) || (i > 229 && i < 240);
      rd(i[7:0]);
      chk("resp", rsp_q, err ? `TVIO_RESP_SLVERR : `TVIO_RESP_OKAY);
      // board holds every pin high; port 5 bit 0 shows the delayed reset
      chk("reset value", rd_q, err ? 8'h00 : i == 229 ? 8'hFE : i < 240 ? `TVIO_DATA_RST :
          i == 255 ? 8'h02 : `TVIO_CFG_RST);
    end
    @(negedge aclk);
    chk("reset oe", pad_oe, 40'h01_0000_0000);
    $display("test reset done");

    wr(8'hE0, 8'hA5);
    wr(8'hE1, 8'h55);
    chk("unmapped write", rsp_q, `TVIO_RESP_SLVERR);
    wr(8'hF0, 8'h0C);
    wr(8'hF1, 8'hF0);
    wr(8'hF2, 8'hC4);
    ext_en <= 40'h0D;
    ext_val <= 40'h0D;
    delayed_reset_src <= 1'b1;
    @(negedge aclk);
    chk("p0 oe", pad_oe[7:0], 8'h72);
    chk("p0 out", pad_out[7:0] & 8'h72, 8'h20);
    chk("p0 level", pad_cmos_sel[7:0] & 8'h0F, 8'h04);
    chk("p50", {pad_oe[32], pad_out[32]}, 2'b11);
    rd(8'hE0);
    chk("p0 read", rd_q, 8'hAD);
    wr(8'hE0, 8'h00, 4'h0);
    rd(8'hE0);
    chk("p0 masked", rd_q, 8'hAD);
    $display("test modes done");

    wr(8'hF3, 8'h8E);
    wr(8'hF4, 8'h8E);
    wr(8'hF5, 8'h0E);
    wr(8'hF8, 8'h05);
    ext_en <= 40'h0E00;
    ext_val <= 40'h0E00;
    @(negedge aclk);
    chk("analog", {analog_path_en, alt_pin_level[11:9]}, {8'h0E, 3'b000});
    chk("schmitt", pad_cmos_sel[18:16], 3'b100);
    chk("pix", {pad_oe[15], pad_out[15]}, 2'b10);
    for (int k = 1; k < 3; k++) begin
      @(posedge aclk) pixel_tick <= 1'b1;
      @(posedge aclk) pixel_tick <= 1'b0;
      @(negedge aclk) chk("pix", pad_out[15], k % 2);
    end
    $display("test analog done");

    wr(8'hF9, 8'h03);
    wr(8'hFA, 8'h03);
    wr(8'hFB, 8'h03);
    twowire_clock_drive <= 4'h7;
    @(negedge aclk) chk("tw drive", {pad_oe[24], pad_out[24], twowire_clock_in[3]}, 3'b100);
    @(posedge aclk) twowire_clock_drive <= 4'hF;
    ext_en <= 40'h03_0000_00;
    ext_val <= 40'h02_0000_00;
    @(negedge aclk) chk("tw free", {pad_oe[25:24], twowire_data_in[3], twowire_clock_in[3]}, 4'h2);
    wr(8'hFF, 8'h01);
    wr(8'hF9, 8'hF3);
    wr(8'hFA, 8'hF3);
    wr(8'hFB, 8'h00);
    pulse_out <= 8'hA6;
    ext_en <= 40'h0;
    @(negedge aclk);
    chk("pulse", {pad_oe[31:28], pad_oe[25:24], pad_out[31:28], pad_out[25:24]}, 12'hFEA);
    rd(8'hFF);
    chk("alt select", rd_q, 8'h03);
    wr(8'hFC, 8'h60);
    wr(8'hFD, 8'h60);
    @(negedge aclk) chk("p5", {pad_oe[32], pad_out[38:37]}, 3'b001);
    rd(8'hFF);
    chk("alt select", rd_q, 8'h01);
    $display("test alternate done");

    // pin reset lands between clock edges: no clock may be needed
    @(posedge aclk) ext_reset_n <= 1'b0;
    delayed_reset_src <= 1'b0;
    #1 chk("pin reset oe", pad_oe, 40'h01_0000_0000);
    chk("pin reset out", pad_out[32], 1'b0);
    @(posedge aclk) ext_reset_n <= 1'b1;
    @(negedge aclk) chk("pin release", pad_oe, 40'h01_0000_0000);
    rd(8'hFF);
    chk("hold again", rd_q, 8'h02);
    $display("test pin reset done");
    end_of_test;
  end
endmodule

`default_nettype wire
